// >>> include/cs_cfg.svh
// timing counts, trace codes and configuration bit positions for the conversion sequencer
// assumes a single system clock; counts are in clock cycles
`ifndef CS_CFG_SVH
`define CS_CFG_SVH
`define CS_ADC_CYCLES 130585
`define CS_DSP_CYCLES 3220
`define CS_EOC_CYCLES 8
`define CS_TRACE_PERIOD 16
`define CS_TRACE_LEAD 9
`define CS_TRST_MIN 16
`define CS_CFG_REPEAT_BIT 15
`define CS_CFG_OPAMP_PD_BIT 0
`define CS_CODE_TEMP 8'hd8
`define CS_CODE_SIG 8'hd9
`define CS_CODE_OUT 8'hea
`define CS_PTR_TEMP 8'h01
`define CS_PTR_SIG 8'h3b
`define CS_PTR_OUT 8'h65
`endif

// >>> include/cs_pkg.sv
// types shared by the conversion sequencer
// no dependencies
`default_nettype none
package cs_pkg;
  typedef enum logic [2:0] {
    CS_IDLE = 3'h0,
    CS_ADC = 3'h1,
    CS_DSP = 3'h2,
    CS_EOC = 3'h3,
    CS_WAIT_LOW = 3'h4
  } cs_state_e;
endpackage
`default_nettype wire

// >>> hw/cs_sequencer.sv
// conversion sequencer: adc phase, dsp trace phase, done strobe, density dac output
// assumes start, trace reset and the data inputs are synchronous to clk_sys
// Summary of operation
// - coefficient trace codes d0-d7 at fixed pointers
// - d8 temperature, d9 signal, ea output traced
// - adc 130585, dsp 3220, eoc eight cycles
// - output word stable at done falling edge
// - temperature first half, then sensor sample
// - start high at power-up converts automatically
// - repeat setting restarts conversions unaided
// - output word becomes density bitstream
// - power-down bit disables the op amp
// - test start drives both trace pins
// - trace every 16n+9 cycles after start of the first dsp phase after test start
// - test reset low floats pin at once, 16 cycles low ends the session
`include "cs_cfg.svh"
`default_nettype none
module cs_sequencer #(
  parameter int ADC_CYCLES = `CS_ADC_CYCLES,
  parameter int DSP_CYCLES = `CS_DSP_CYCLES,
  parameter int STEPS = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic start,
  input wire logic test_start,
  input wire logic trace_rstn,
  input wire logic [15:0] config_word,
  input wire logic [15:0] coeff [8],
  input wire logic [15:0] temp_sample,
  input wire logic [15:0] sig_sample,
  input wire logic [11:0] comp_word,
  output logic sample_temp,
  output logic sample_sig,
  output logic eoc,
  output logic [11:0] data_out,
  output logic dac_out,
  output logic opamp_en,
  output logic trace_serial_out,
  output logic trace_io_out,
  output logic trace_io_oe
);
  // pointer shown on the io pin for each trace step
  localparam logic [7:0] PTRS [STEPS] = '{
    8'h66,
    8'h47,
    8'h11,
    8'h2e,
    8'h38,
    8'h03,
    8'h22,
    8'h56,
    `CS_PTR_TEMP,
    `CS_PTR_SIG,
    `CS_PTR_OUT,
    8'h00,
    8'h00,
    8'h00,
    8'h00,
    8'h00
  };
  logic [1:0] rst_sync_q;
  logic rst_n;
  cs_pkg::cs_state_e state_q;
  cs_pkg::cs_state_e state_d;
  logic [17:0] cnt_q;
  logic start_q;
  logic test_q;
  logic [11:0] data_q;
  logic [12:0] acc_q;
  logic [3:0] step_q;
  logic [4:0] bit_q;
  logic [4:0] trst_q;
  logic [15:0] s_reg;
  logic [15:0] s_sh_q;
  logic [15:0] pp_sh_q;
  logic [7:0] ps_code;
  logic [7:0] pp_val;
  logic tracing_q;
  logic go;
  logic adc_done;
  logic dsp_done;
  logic eoc_done;
  logic half;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  assign adc_done = (state_q == cs_pkg::CS_ADC) && (cnt_q == 18'(ADC_CYCLES - 1));
  assign dsp_done = (state_q == cs_pkg::CS_DSP) && (cnt_q == 18'(DSP_CYCLES - 1));
  assign eoc_done = (state_q == cs_pkg::CS_EOC) && (cnt_q == 18'(`CS_EOC_CYCLES - 1));
  assign half = cnt_q < 18'(ADC_CYCLES / 2);
  // rising start, start held high out of reset, or test start
  assign go = (start && !start_q) || test_start;
  assign sample_temp = (state_q == cs_pkg::CS_ADC) && half;
  assign sample_sig = (state_q == cs_pkg::CS_ADC) && !half;
  assign eoc = state_q == cs_pkg::CS_EOC;
  assign data_out = data_q;
  assign opamp_en = !config_word[`CS_CFG_OPAMP_PD_BIT];
  assign dac_out = acc_q[12];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cs_pkg::CS_IDLE: begin
        if (go) state_d = cs_pkg::CS_ADC;
      end
      cs_pkg::CS_ADC: begin
        if (adc_done) state_d = cs_pkg::CS_DSP;
      end
      cs_pkg::CS_DSP: begin
        if (dsp_done) state_d = cs_pkg::CS_EOC;
      end
      cs_pkg::CS_EOC: if (eoc_done) begin
        if (config_word[`CS_CFG_REPEAT_BIT]) state_d = cs_pkg::CS_ADC;
        else state_d = cs_pkg::CS_WAIT_LOW;
      end
      cs_pkg::CS_WAIT_LOW: begin
        if (!start) state_d = cs_pkg::CS_IDLE;
      end
      default: state_d = cs_pkg::CS_IDLE;
    endcase
  end

  // counter restarts on every state change
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= cs_pkg::CS_IDLE;
      cnt_q <= 18'h0;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      start_q <= start;
      cnt_q <= (state_d != state_q) ? 18'h0 : cnt_q + 18'h1;
    end
  end

  // word updates at end of dsp, stays through the whole done pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) data_q <= 12'h000;
    else if (dsp_done) data_q <= comp_word;
  end

  // first-order density modulator
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) acc_q <= 13'h0000;
    else acc_q <= {1'b0, acc_q[11:0]} + {1'b0, data_q};
  end

  // trace session: latched by test start, ended by trace reset held low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      test_q <= 1'b0;
      trst_q <= 5'h00;
    end else begin
      if (trace_rstn) trst_q <= 5'h00;
      else if (trst_q != 5'h1f) trst_q <= trst_q + 5'h01;
      if (test_start) test_q <= 1'b1;
      else if (trst_q >= 5'(`CS_TRST_MIN - 1)) test_q <= 1'b0;
    end
  end

  // steps past the output word trace as zero
  always_comb begin
    s_reg = 16'h0000;
    ps_code = 8'h00;
    if (step_q < 4'h8) begin
      s_reg = coeff[step_q[2:0]];
      ps_code = 8'hd0 + {5'h00, step_q[2:0]};
    end else if (step_q == 4'h8) begin
      s_reg = temp_sample;
      ps_code = `CS_CODE_TEMP;
    end else if (step_q == 4'h9) begin
      s_reg = sig_sample;
      ps_code = `CS_CODE_SIG;
    end else if (step_q == 4'ha) begin
      s_reg = {4'h0, comp_word};
      ps_code = `CS_CODE_OUT;
    end
  end
  assign pp_val = PTRS[step_q];

  // one step per 16 cycles after a 9-cycle lead
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tracing_q <= 1'b0;
      step_q <= 4'h0;
      bit_q <= 5'h00;
      s_sh_q <= 16'h0000;
      pp_sh_q <= 16'h0000;
    end else if (test_start) begin
      tracing_q <= 1'b1;
      step_q <= 4'h0;
      bit_q <= 5'(`CS_TRACE_LEAD - 1);
    end else if (tracing_q && state_q == cs_pkg::CS_DSP) begin
      if (bit_q == 5'h00) begin
        s_sh_q <= s_reg;
        pp_sh_q <= {pp_val, ps_code};
        bit_q <= 5'(`CS_TRACE_PERIOD - 1);
        step_q <= (step_q == 4'ha) ? 4'h0 : step_q + 4'h1;
      end else begin
        bit_q <= bit_q - 5'h01;
        s_sh_q <= {1'b0, s_sh_q[15:1]};
        pp_sh_q <= {1'b0, pp_sh_q[15:1]};
      end
    end else if (!test_q) begin
      tracing_q <= 1'b0;
    end
  end

  assign trace_serial_out = s_sh_q[0];
  assign trace_io_out = pp_sh_q[0];
  assign trace_io_oe = test_q && trace_rstn;
endmodule
`default_nettype wire

// >>> bench/cs_seq_properties.sv
// port checks for the sequencer
// assumes one clock, clk_sys, reset rstn
`default_nettype none
module cs_seq_properties (
  input wire logic clk_sys, rstn, trace_rstn, sample_temp, sample_sig, eoc, opamp_en, trace_io_oe,
  input wire logic [15:0] config_word,
  input wire logic [11:0] data_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  eoc_width_a: assert property ($rose(eoc) |-> eoc [*8] ##1 !eoc) else $error("eoc width");
  dsp_gap_a: assert property ($fell(sample_sig) |-> !eoc [*8]) else $error("eoc early");
  out_hold_a: assert property (eoc && $past(eoc) |-> $stable(data_out)) else $error("data moved");
  temp_first_a: assert property ($rose(sample_sig) |-> $past(sample_temp)) else $error("order");
  one_input_a: assert property (!(sample_temp && sample_sig)) else $error("overlap");
  rep_start_a: assert property ($fell(eoc) && config_word[15] |-> sample_temp) else $error("no restart");
  opamp_pd_a: assert property (opamp_en == !config_word[0]) else $error("opamp");
  trst_float_a: assert property (!trace_rstn |-> !trace_io_oe) else $error("pin driven");
endmodule
bind cs_sequencer cs_seq_properties u_props (.*);
`default_nettype wire

// >>> bench/cs_host.sv
// host: drops start one cycle after done fall unless repeat, latches output on done fall
// assumes start sampled on rising clock
`default_nettype none
module cs_host (
  input wire logic clk_sys,
  input wire logic eoc,
  input wire logic repeat_on,
  input wire logic run,
  input wire logic [11:0] data_out,
  output logic start,
  output logic [11:0] latched
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drop = 1'b0;
  assign start = run && !drop;
  always @(negedge eoc) begin
    latched <= data_out;
    if (!repeat_on) begin
      @(negedge clk_sys) drop <= 1'b1;
      @(negedge clk_sys) drop <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// bench top: scenarios and verdict
// assumes sequencer, host and checker compiled
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rstn = 0, test_start = 0, trace_rstn = 1, run = 1, start, st, ss, eoc, dac, opamp_en, oe;
  logic tso, tio;
  logic [15:0] config_word = 16'h0000;
  logic [15:0] coeff [8] = '{0: 16'h1234, default: 16'h0000};
  logic [11:0] comp_word = 12'h5a3, data_out, latched;
  int failures = 0, checks = 0, cyc = 0;
  always #2 clk_sys = ~clk_sys;
  cs_sequencer #(.ADC_CYCLES(200), .DSP_CYCLES(40)) u_dut (.clk_sys, .rstn, .start, .test_start, .trace_rstn,
    .config_word, .coeff, .temp_sample(16'h0123), .sig_sample(16'h0456), .comp_word, .sample_temp(st),
    .sample_sig(ss), .eoc, .data_out, .dac_out(dac), .opamp_en, .trace_serial_out(tso), .trace_io_out(tio),
    .trace_io_oe(oe));
  cs_host u_host (.clk_sys, .eoc, .repeat_on(config_word[15]), .run, .data_out, .start, .latched);
  task automatic chk(logic [11:0] g, logic [11:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic w_done();
    int n = 0;
    while (eoc !== 1'b1 && n < 600) begin @(negedge clk_sys); n++; end
    while (eoc === 1'b1 && n < 600) begin @(negedge clk_sys); n++; end
    chk(12'(n < 600), 12'h001);
  endtask
  task automatic t_auto();
    int a = 0, t = 0;
    while (st !== 1'b1 && a < 600) begin @(negedge clk_sys); a++; end
    a = 0;
    while (st === 1'b1 || ss === 1'b1) begin
      t += int'(st);
      @(negedge clk_sys);
      a++;
    end
    chk(12'(a), 12'd200);
    chk(12'(t), 12'd100);
    w_done();
    chk(latched, 12'h5a3);
  endtask
  task automatic t_opamp();
    config_word = 16'h0001;
    @(negedge clk_sys);
    chk({11'h0, opamp_en}, 12'h000);
    config_word = 16'h0000;
    @(negedge clk_sys);
    chk({11'h0, opamp_en}, 12'h001);
  endtask
  task automatic t_rep();
    config_word = 16'h8000;
    comp_word = 12'h0ff;
    w_done();
    w_done();
    chk(latched, 12'h0ff);
    config_word = 16'h0000;
  endtask
  task automatic t_trace();
    int n = 0;
    logic [15:0] pw = 16'h0000;
    logic [15:0] sw = 16'h0000;
    run = 0;
    w_done();
    repeat (3) @(negedge clk_sys);
    test_start = 1;
    @(negedge clk_sys);
    test_start = 0;
    while (oe !== 1'b1 && n < 600) begin @(negedge clk_sys); n++; end
    chk({11'h0, oe}, 12'h001);
    while (ss !== 1'b1 && n < 600) begin @(negedge clk_sys); n++; end
    while (ss === 1'b1 && n < 600) begin @(negedge clk_sys); n++; end
    repeat (9) @(negedge clk_sys);
    for (int i = 0; i < 16; i++) begin
      pw[i] = tio;
      sw[i] = tso;
      @(negedge clk_sys);
    end
    chk({4'h0, pw[7:0]}, 12'h0d0);
    chk({4'h0, pw[15:8]}, 12'h066);
    chk(sw[11:0], 12'h234);
    w_done();
    trace_rstn = 0;
    @(negedge clk_sys);
    chk({11'h0, oe}, 12'h000);
    repeat (16) @(negedge clk_sys);
    trace_rstn = 1;
  endtask
  task automatic t_dac();
    int ones = 0;
    repeat (4096) begin
      @(negedge clk_sys);
      ones += int'(dac);
    end
    chk(12'(ones), 12'h0ff);
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    rstn = 1;
    t_auto();
    t_opamp();
    t_rep();
    t_trace();
    t_dac();
    stop_test();
  end
endmodule
`default_nettype wire
